// ==== logic/tbo_guard.sv ====
`timescale 1ns/1ps
module tbo_guard
  import tbo_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic contact_a,
  input wire logic contact_b,
  input wire logic start_in,
  input wire logic preexcite_in,
  input wire logic encoder_fitted,
  input wire logic vector_speed_ctl,
  input wire logic [15:0] analog_bias_pct,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] speed_cmd,
  input wire logic [15:0] actual_speed,
  input wire logic decelerating,
  output logic signed [15:0] torque_bias,
  output logic bias_active,
  output logic ain1_torque_mode,
  output logic main_speed_zero,
  output logic [15:0] freq_clamp,
  output logic speed_deviation_fault,
  output logic auto_setting
);
  // ==========================================================
  // Pin synchronisers
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
    end
    else
    begin
      pin_s1_q <= {vector_speed_ctl, encoder_fitted, preexcite_in,
                   contact_b, contact_a};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic ca_s, cb_s, pre_s, enc_s, vec_s;
  assign ca_s = pin_s2_q[0];
  assign cb_s = pin_s2_q[1];
  assign pre_s = pin_s2_q[2];
  assign enc_s = pin_s2_q[3];
  assign vec_s = pin_s2_q[4];

  // ==========================================================
  // AHB-Lite slave, zero wait states
  logic wr_q;
  logic [7:0] wa_q;
  logic [15:0] src_q, b1_q, b2_q, b3_q, filt_q, hold_q, ain1f_q, aisel_q;
  logic [15:0] dthr_q, dtime_q, margin_q, restart_q, maxf_q;
  logic [15:0] wd;
  logic ok_bias;
  assign wd = hwdata[15:0];
  assign ok_bias = (wd >= BIAS_MIN && wd <= BIAS_MAX) || wd == NOT_SET; // R2
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end
    else
    begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      wa_q <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      src_q <= NOT_SET;
      b1_q <= NOT_SET;
      b2_q <= NOT_SET;
      b3_q <= NOT_SET;
      filt_q <= NOT_SET;
      hold_q <= NOT_SET;
      ain1f_q <= 16'h0000;
      aisel_q <= 16'h0000;
      dthr_q <= NOT_SET;
      dtime_q <= DTIME_RST;
      margin_q <= MARGIN_RST;
      restart_q <= NOT_SET;
      maxf_q <= MAXF_RST;
    end
    else if (wr_q)
    begin
      case (wa_q)
        ADDR_SRC: if (wd <= 16'h0003 || wd == NOT_SET) src_q <= wd;
        ADDR_BIAS1: if (ok_bias) b1_q <= wd; // R2
        ADDR_BIAS2: if (ok_bias) b2_q <= wd; // R2
        ADDR_BIAS3: if (ok_bias) b3_q <= wd; // R2
        ADDR_FILT: filt_q <= wd;
        ADDR_HOLD: hold_q <= wd;
        ADDR_AIN1F: ain1f_q <= wd;
        ADDR_AISEL: aisel_q <= wd;
        ADDR_DTHR: if (wd <= DTHR_MAX || wd == NOT_SET) dthr_q <= wd;
        ADDR_DTIME: if (enc_s && wd <= DTIME_MAX) dtime_q <= wd; // R17
        ADDR_MARGIN: if (enc_s && wd <= MARGIN_MAX) margin_q <= wd; // R17
        ADDR_RESTART: restart_q <= wd;
        ADDR_MAXF: maxf_q <= wd;
        default: ;
      endcase
    end
  end
  logic [15:0] rd;
  always_comb
  begin
    rd = 16'h0000;
    case (haddr[7:0])
      ADDR_SRC: rd = src_q;
      ADDR_BIAS1: rd = b1_q;
      ADDR_BIAS2: rd = b2_q;
      ADDR_BIAS3: rd = b3_q;
      ADDR_FILT: rd = filt_q;
      ADDR_HOLD: rd = hold_q;
      ADDR_AIN1F: rd = ain1f_q;
      ADDR_AISEL: rd = aisel_q;
      ADDR_DTHR: rd = dthr_q;
      ADDR_DTIME: rd = dtime_q;
      ADDR_MARGIN: rd = margin_q;
      ADDR_RESTART: rd = restart_q;
      ADDR_MAXF: rd = maxf_q;
      ADDR_STATUS: rd = {10'h000, enc_s, main_speed_zero, ain1_torque_mode,
                         auto_setting, bias_active, speed_deviation_fault};
      ADDR_BIASOUT: rd = torque_bias;
      ADDR_CLAMP: rd = freq_clamp;
      default: rd = 16'h0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hsel && hready && htrans[1] && !hwrite)
      hrdata <= {16'h0000, rd};
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================
  // Bias target selection
  logic signed [15:0] target;
  logic [15:0] csel;
  always_comb
  begin
    csel = NOT_SET;
    target = 16'sh0000;
    case (src_q)
      16'h0000:
      begin
        case ({cb_s, ca_s}) // R1
          2'b01: csel = b1_q;
          2'b10: csel = b2_q;
          2'b11: csel = b3_q;
          default: csel = NOT_SET;
        endcase
        if (csel != NOT_SET)
          target = $signed(csel - BIAS_ZERO); // R2
      end
      16'h0001, 16'h0002:
        if (ain1f_q == AIN1_TORQUE) // R4
          target = $signed(analog_bias_pct);
      default: target = 16'sh0000; // R18
    endcase
  end

  // ==========================================================
  // Rise filter and hold timer
  logic tick;
  tbo_tick #(.DIV(TICK_CYCLES)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );
  tbo_bias_e bs_q;
  logic start_q;
  logic [15:0] htim_q;
  logic signed [31:0] acc_q;
  logic no_filt;
  logic [15:0] hold_n;
  assign no_filt = filt_q == NOT_SET || filt_q == 16'h0000; // R19
  assign hold_n = (hold_q == NOT_SET) ? 16'h0000 : hold_q; // R19
  logic signed [31:0] err, fdiv;
  assign err = (32'(target) <<< 8) - acc_q;
  assign fdiv = $signed({16'h0000, filt_q});
  logic go;
  assign go = start_in && !start_q && !pre_s; // R8
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bs_q <= BS_IDLE;
      start_q <= 1'b0;
      htim_q <= 16'h0000;
      acc_q <= 32'sh0000_0000;
    end
    else
    begin
      start_q <= start_in;
      case (bs_q)
        BS_IDLE:
          if (go && src_q != NOT_SET && src_q != 16'h0003)
          begin
            bs_q <= BS_RISE;
            htim_q <= hold_n;
            acc_q <= no_filt ? 32'(target) <<< 8 : 32'sh0000_0000;
          end
        BS_RISE:
          if (no_filt || (acc_q >>> 8) == 32'(target))
            bs_q <= BS_HOLD;
          else if (tick) // R6
            acc_q <= acc_q + (err > 32'sh0 ? err + fdiv - 32'sh1 : err)
                     / fdiv;
        BS_HOLD: // R7
          if (htim_q == 16'h0000)
            bs_q <= BS_DONE;
          else if (tick)
            htim_q <= htim_q - 16'h0001;
        BS_DONE: ;
        default: bs_q <= BS_IDLE;
      endcase
      if (!start_in || src_q == NOT_SET) // R18
        bs_q <= BS_IDLE;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      torque_bias <= 16'sh0000;
      bias_active <= 1'b0;
      ain1_torque_mode <= 1'b0;
      main_speed_zero <= 1'b0;
      auto_setting <= 1'b0;
    end
    else
    begin
      torque_bias <= (bs_q == BS_RISE || bs_q == BS_HOLD)
                     ? acc_q[23:8] : 16'sh0000; // R7
      bias_active <= bs_q == BS_RISE || bs_q == BS_HOLD;
      ain1_torque_mode <= bias_active && ain1f_q == AIN1_TORQUE; // R9
      main_speed_zero <= bias_active && ain1f_q == AIN1_TORQUE
                         && aisel_q >= AISEL_OVR; // R10
      auto_setting <= src_q == 16'h0003; // R5
    end
  end

  // ==========================================================
  // Overrun clamp
  logic [15:0] peak_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      peak_q <= 16'h0000;
      freq_clamp <= MARGIN_RST;
    end
    else
    begin
      if (!start_in)
        peak_q <= set_freq;
      else if (set_freq > peak_q) // R14
        peak_q <= set_freq;
      if (restart_q != NOT_SET) // R15
        freq_clamp <= 16'(maxf_q + margin_q);
      else if (decelerating) // R14
        freq_clamp <= 16'(speed_cmd + margin_q);
      else
        freq_clamp <= 16'(peak_q + margin_q); // R13
    end
  end

  // ==========================================================
  // Speed deviation supervision
  logic [15:0] dev;
  logic [31:0] dcnt_q;
  logic over;
  assign dev = speed_cmd > actual_speed ? speed_cmd - actual_speed
               : actual_speed - speed_cmd;
  assign over = dthr_q != NOT_SET && vec_s && dev > dthr_q; // R11
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dcnt_q <= 32'h0000_0000;
      speed_deviation_fault <= 1'b0;
    end
    else
    begin
      if (!over)
        dcnt_q <= 32'h0000_0000; // R20
      else if (tick && dcnt_q != 32'hffff_ffff)
        dcnt_q <= dcnt_q + 32'h0000_0001;
      // Trip latches until reset; a drive fault needs an explicit reset
      if (over && dcnt_q > 32'(dtime_q) * DTIME_DIV) // R12
        speed_deviation_fault <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  property p_dev_reset;
    @(posedge hclk) disable iff (!hresetn)
      !over |=> dcnt_q == 32'h0000_0000;
  endproperty
  a_dev_reset: assert property (p_dev_reset) else $error("timer kept"); // R20
  property p_no_sup;
    @(posedge hclk) disable iff (!hresetn)
      dthr_q == NOT_SET && !speed_deviation_fault |=> !speed_deviation_fault;
  endproperty
  a_no_sup: assert property (p_no_sup) else $error("trip disabled"); // R11
  property p_trip;
    @(posedge hclk) disable iff (!hresetn)
      over && dcnt_q > 32'(dtime_q) * DTIME_DIV |=> speed_deviation_fault;
  endproperty
  a_trip: assert property (p_trip) else $error("no trip"); // R12
  property p_clamp;
    @(posedge hclk) disable iff (!hresetn)
      restart_q == NOT_SET && !decelerating |=> freq_clamp ==
      $past(peak_q) + $past(margin_q);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp wrong"); // R13
  property p_peak;
    @(posedge hclk) disable iff (!hresetn)
      start_in && $past(start_in) |-> peak_q >= $past(peak_q);
  endproperty
  a_peak: assert property (p_peak) else $error("clamp lowered"); // R14
  property p_restart;
    @(posedge hclk) disable iff (!hresetn)
      restart_q != NOT_SET |=> freq_clamp == $past(maxf_q) + $past(margin_q);
  endproperty
  a_restart: assert property (p_restart) else $error("restart clamp"); // R15
  property p_enc;
    @(posedge hclk) disable iff (!hresetn)
      !enc_s |=> $stable(margin_q) && $stable(dtime_q);
  endproperty
  a_enc: assert property (p_enc) else $error("write w/o encoder"); // R17
  property p_nobias;
    @(posedge hclk) disable iff (!hresetn)
      src_q == NOT_SET [*2] |=> torque_bias == 16'sh0000;
  endproperty
  a_nobias: assert property (p_nobias) else $error("bias w/o source"); // R18
  property p_tq;
    @(posedge hclk) disable iff (!hresetn)
      bias_active && ain1f_q == AIN1_TORQUE |=> ain1_torque_mode;
  endproperty
  a_tq: assert property (p_tq) else $error("terminal mode"); // R9
  property p_start;
    @(posedge hclk) disable iff (!hresetn)
      $rose(start_in) && !pre_s && src_q != NOT_SET && src_q != 16'h0003
      |=> bs_q == BS_RISE;
  endproperty
  a_start: assert property (p_start) else $error("bias late"); // R8
endmodule : tbo_guard

// ==== logic/tbo_pkg.sv ====
// Functional notes
// R1: Source 0 picks bias from two contacts; none gives 0%, else setting 1..3.
// R2: Contact bias settings 600..1400 mean percentage equal to setting minus 1000.
// R3: Configurer assigns terminal codes 42 and 43 to the two contacts.
// R4: Source 1 or 2 takes bias from analog terminal 1 set to function 6.
// R5: Source 3 runs auto-setting; bias resumes only after reselecting 1 or 2; code also resumes bias after source 0 is written.
// R6: Filter setting other than 9999 shapes bias rise by first-order lag.
// R7: Output torque follows bias command alone for the hold time.
// R8: Without pre-excitation, bias applies together with the start signal.
// R9: Bias active with terminal 1 function 6 makes terminal 1 a torque input.
// R10: Then override with terminal 1 as main speed forces main speed to 0Hz.
// R11: Deviation threshold 9999 disables speed deviation supervision.
// R12: Deviation above threshold longer than deviation time trips fault.
// R13: Output frequency clamps at set frequency plus overrun margin.
// R14: Clamp never lowers after start; deceleration limits to command plus margin.
// R15: Auto restart enabled clamps to maximum frequency plus margin.
// R16: Configurer should set margin to 120Hz when encoder count is correct.
// R17: Deviation time and margin writable only with encoder option fitted.
// R18: Source 9999 applies no bias, rated torque 100%.
// R19: Filter or hold time 9999 behaves as zero seconds.
// R20: Deviation timer restarts when deviation falls to threshold or below.
package tbo_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_SRC = 8'h00;
  localparam logic [7:0] ADDR_BIAS1 = 8'h04;
  localparam logic [7:0] ADDR_BIAS2 = 8'h08;
  localparam logic [7:0] ADDR_BIAS3 = 8'h0c;
  localparam logic [7:0] ADDR_FILT = 8'h10;
  localparam logic [7:0] ADDR_HOLD = 8'h14;
  localparam logic [7:0] ADDR_AIN1F = 8'h18;
  localparam logic [7:0] ADDR_AISEL = 8'h1c;
  localparam logic [7:0] ADDR_DTHR = 8'h20;
  localparam logic [7:0] ADDR_DTIME = 8'h24;
  localparam logic [7:0] ADDR_MARGIN = 8'h28;
  localparam logic [7:0] ADDR_RESTART = 8'h2c;
  localparam logic [7:0] ADDR_MAXF = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  localparam logic [7:0] ADDR_BIASOUT = 8'h38;
  localparam logic [7:0] ADDR_CLAMP = 8'h3c;
  // ==========================================================
  // Values and reset values
  localparam logic [15:0] NOT_SET = 16'h270f;
  localparam logic [15:0] BIAS_ZERO = 16'h03e8;
  localparam logic [15:0] BIAS_MIN = 16'h0258;
  localparam logic [15:0] BIAS_MAX = 16'h0578;
  localparam logic [15:0] RATED_PCT = 16'h0064;
  localparam logic [15:0] AIN1_TORQUE = 16'h0006;
  localparam logic [15:0] DTIME_RST = 16'h000a;
  localparam logic [15:0] MARGIN_RST = 16'h0014;
  localparam logic [15:0] MARGIN_MAX = 16'h0078;
  localparam logic [15:0] DTHR_MAX = 16'h001e;
  localparam logic [15:0] DTIME_MAX = 16'h03e8;
  localparam logic [15:0] MAXF_RST = 16'h0078;
  localparam logic [15:0] AISEL_OVR = 16'h0004;
  // Filter and hold times in 10 ms units, deviation time in 100 ms units
  localparam int TICK_NS = 10_000_000;
  localparam int CLK_NS = 5;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int DTIME_DIV = 10;
  // Status bit positions
  localparam int ST_FAULT = 0;
  localparam int ST_HOLD = 1;
  localparam int ST_AUTO = 2;
  localparam int ST_AIN1_TQ = 3;
  localparam int ST_MAIN0 = 4;
  localparam int ST_ENC = 5;
  typedef enum logic [1:0] {BS_IDLE, BS_RISE, BS_HOLD, BS_DONE} tbo_bias_e;
endpackage : tbo_pkg

// ==== logic/tbo_tick.sv ====
`timescale 1ns/1ps
// ==========================================================
// Free-running tick divider
module tbo_tick
  import tbo_pkg::*;
#(
  parameter int DIV = 2
)(
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick
);
  logic [31:0] cnt_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else if (cnt_q == 32'(DIV - 1))
    begin
      cnt_q <= 32'h0000_0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule : tbo_tick

// ==== dv/tbo_field.sv ====
`timescale 1ns/1ps
// ==============================
// Field side: contacts and terminal 1
module tbo_field
  import tbo_pkg::*;
(
  input wire logic hclk,
  input wire logic [1:0] sel,
  input wire logic slow,
  input wire logic [15:0] level,
  output logic contact_a,
  output logic contact_b,
  output logic [15:0] analog_bias_pct
);
  // Slow mode lags three cycles, like a settling front end
  logic [1:0] sel_q [3];
  logic [15:0] lvl_q [3];
  always_ff @(posedge hclk)
  begin
    sel_q[0] <= sel;
    sel_q[1] <= sel_q[0];
    sel_q[2] <= sel_q[1];
    lvl_q[0] <= level;
    lvl_q[1] <= lvl_q[0];
    lvl_q[2] <= lvl_q[1];
  end
  // Terminals wired for function codes 42 and 43
  assign contact_a = slow ? sel_q[2][0] : sel_q[0][0];
  assign contact_b = slow ? sel_q[2][1] : sel_q[0][1];
  // Terminal 1 set to function 6 carries the load level
  assign analog_bias_pct = slow ? lvl_q[2] : lvl_q[0];
endmodule : tbo_field

// ==== dv/test_torque_bias_and_overrun_guard.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: %0h vs %0h", $time, g, e); end end
`define WAITC(c) begin wd = 0; while (!(c) && wd < 200) begin \
  @(posedge hclk); wd++; end end
// ==============================
// Bench top
module test_torque_bias_and_overrun_guard
  import tbo_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, start_in;
  logic preexcite_in, encoder_fitted, vector_speed_ctl, decelerating;
  logic slow, contact_a, contact_b, bias_active, ain1_torque_mode;
  logic main_speed_zero, speed_deviation_fault, auto_setting;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, sel;
  logic [2:0] hsize;
  logic [15:0] analog_bias_pct, level, set_freq, speed_cmd, actual_speed;
  logic [15:0] freq_clamp;
  logic signed [15:0] torque_bias, exp_b;
  logic [15:0] bset [3];
  int errors, compares, wd;
  assign hready = hreadyout;
  // Short tick keeps filter and timer runs brief
  tbo_guard #(.TICK_CYCLES(4)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .contact_a(contact_a),
    .contact_b(contact_b), .start_in(start_in),
    .preexcite_in(preexcite_in), .encoder_fitted(encoder_fitted),
    .vector_speed_ctl(vector_speed_ctl), .analog_bias_pct(analog_bias_pct),
    .set_freq(set_freq), .speed_cmd(speed_cmd),
    .actual_speed(actual_speed), .decelerating(decelerating),
    .torque_bias(torque_bias), .bias_active(bias_active),
    .ain1_torque_mode(ain1_torque_mode), .main_speed_zero(main_speed_zero),
    .freq_clamp(freq_clamp), .speed_deviation_fault(speed_deviation_fault),
    .auto_setting(auto_setting));
  tbo_field field (.hclk(hclk), .sel(sel), .slow(slow), .level(level),
    .contact_a(contact_a), .contact_b(contact_b),
    .analog_bias_pct(analog_bias_pct));
  // ==============================
  // Bus tasks
  task ahb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task wr(input logic [7:0] a, input logic [15:0] d);
    ahb(1'b1, a, d);
  endtask : wr
  task chk_rd(input logic [7:0] a, input logic [15:0] e);
    ahb(1'b0, a, 16'h0000);
    `CHK(rd, {16'h0000, e})
  endtask : chk_rd
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task done(input string s);
    $display("test %s ended, errors %0d", s, errors);
  endtask : done
  task finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  // ==============================
  // Clock and watchdog
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    #100000;
    errors++;
    finish_test();
  end
  // ==============================
  // Tests
  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00;
    haddr = 32'h0000_0000; hwdata = 32'h0000_0000; hsize = 3'b010;
    start_in = 1'b0; preexcite_in = 1'b0; encoder_fitted = 1'b0;
    vector_speed_ctl = 1'b0; decelerating = 1'b0; slow = 1'b0;
    sel = 2'b00; level = 16'h0000; set_freq = 16'h0000;
    speed_cmd = 16'h0000; actual_speed = 16'h0000;
    bset = '{16'h0401, 16'h03cf, 16'h039d};
    cyc(8);
    hresetn <= 1'b1;
    `CHK(freq_clamp, MARGIN_RST)
    chk_rd(ADDR_SRC, NOT_SET);
    chk_rd(ADDR_DTHR, NOT_SET);
    chk_rd(ADDR_DTIME, DTIME_RST);
    chk_rd(ADDR_MARGIN, MARGIN_RST);
    chk_rd(8'h40, 16'h0000);
    wr(ADDR_DTIME, 16'h0001);
    chk_rd(ADDR_DTIME, DTIME_RST);
    encoder_fitted <= 1'b1;
    cyc(4);
    wr(ADDR_DTIME, 16'h0001);
    chk_rd(ADDR_DTIME, 16'h0001);
    wr(ADDR_BIAS1, 16'h0579);
    chk_rd(ADDR_BIAS1, NOT_SET);
    wr(ADDR_BIAS1, BIAS_MAX);
    chk_rd(ADDR_BIAS1, BIAS_MAX);
    done("registers");
    start_in <= 1'b1;
    cyc(20);
    `CHK(bias_active, 1'b0)
    `CHK(torque_bias, 16'sh0000)
    start_in <= 1'b0;
    done("no bias");
    for (int i = 0; i < 3; i++) wr(ADDR_BIAS1 + 8'(4 * i), bset[i]);
    wr(ADDR_HOLD, 16'h000a);
    wr(ADDR_AIN1F, AIN1_TORQUE);
    wr(ADDR_AISEL, AISEL_OVR);
    wr(ADDR_SRC, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      sel <= 2'(i);
      cyc(8);
      start_in <= 1'b1;
      `WAITC(bias_active === 1'b1)
      `CHK((wd < 4), 1'b1)
      cyc(2);
      exp_b = (i == 0) ? 16'sh0000 : bset[i - 1] - BIAS_ZERO;
      `CHK(torque_bias, exp_b)
      `CHK(ain1_torque_mode, 1'b1)
      `CHK(main_speed_zero, 1'b1)
      `WAITC(bias_active === 1'b0)
      `CHK((wd > 30 && wd < 45), 1'b1)
      start_in <= 1'b0;
    end
    done("contacts");
    wr(ADDR_FILT, 16'h0002);
    wr(ADDR_SRC, 16'h0001);
    slow <= 1'b1;
    level <= 16'h0028;
    cyc(8);
    start_in <= 1'b1;
    `WAITC(bias_active === 1'b1)
    `CHK((torque_bias < 16'sh0028), 1'b1)
    cyc(16);
    `CHK((torque_bias >= 16'sh001e), 1'b1)
    start_in <= 1'b0;
    `WAITC(bias_active === 1'b0)
    done("analog filter");
    wr(ADDR_SRC, 16'h0003);
    cyc(2);
    `CHK(auto_setting, 1'b1)
    chk_rd(ADDR_STATUS, 16'((1 << ST_AUTO) | (1 << ST_ENC)));
    start_in <= 1'b1;
    cyc(20);
    `CHK(bias_active, 1'b0)
    start_in <= 1'b0;
    wr(ADDR_SRC, 16'h0002);
    cyc(2);
    `CHK(auto_setting, 1'b0)
    start_in <= 1'b1;
    `WAITC(bias_active === 1'b1)
    `CHK(bias_active, 1'b1)
    done("auto setting");
    set_freq <= 16'h001e;
    `WAITC(freq_clamp === 16'h0032)
    `CHK(freq_clamp, 16'h0032)
    set_freq <= 16'h000a;
    cyc(10);
    `CHK(freq_clamp, 16'h0032)
    speed_cmd <= 16'h000f;
    decelerating <= 1'b1;
    `WAITC(freq_clamp === 16'h0023)
    `CHK(freq_clamp, 16'h0023)
    decelerating <= 1'b0;
    start_in <= 1'b0;
    wr(ADDR_RESTART, 16'h0000);
    `WAITC(freq_clamp === 16'h008c)
    `CHK(freq_clamp, MAXF_RST + MARGIN_RST)
    wr(ADDR_MARGIN, MARGIN_MAX);
    `WAITC(freq_clamp === 16'h00f0)
    `CHK(freq_clamp, MAXF_RST + MARGIN_MAX)
    wr(ADDR_RESTART, NOT_SET);
    done("clamp");
    vector_speed_ctl <= 1'b1;
    speed_cmd <= 16'h0032;
    actual_speed <= 16'h0028;
    cyc(100);
    `CHK(speed_deviation_fault, 1'b0)
    wr(ADDR_DTHR, 16'h0005);
    cyc(30);
    // Deviation equal to the threshold must not keep counting
    actual_speed <= 16'h002d;
    cyc(10);
    actual_speed <= 16'h0028;
    cyc(30);
    `CHK(speed_deviation_fault, 1'b0)
    `WAITC(speed_deviation_fault === 1'b1)
    `CHK(speed_deviation_fault, 1'b1)
    `CHK((wd > 4 && wd < 30), 1'b1)
    done("deviation");
    finish_test();
  end
endmodule : test_torque_bias_and_overrun_guard
